// >>> clsu_pkg.sv
// package for the coherent line state update block
// shared by the cached master end, the interconnect end and their interface
package clsu_pkg;

  // --------------------------------------------------------------------
  // cache line states
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    CLSU_I,
    CLSU_UC,
    CLSU_UD,
    CLSU_SC,
    CLSU_SD
  } clsu_line_e;

  // --------------------------------------------------------------------
  // coherent request kinds on the read address channel
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    CLSU_RD_NSD,
    CLSU_RD_SHR,
    CLSU_RD_UNQ,
    CLSU_CL_UNQ
  } clsu_op_e;

  // --------------------------------------------------------------------
  // response code layout
  // --------------------------------------------------------------------
  localparam int          RESP_W          = 2;
  localparam int          RESP_SHARED_BIT = 1;
  localparam int          RESP_DIRTY_BIT  = 0;
  localparam logic [1:0]  RESP_UNQ_CLEAN  = 2'h0;

  // --------------------------------------------------------------------
  // default sizes and timing
  // --------------------------------------------------------------------
  localparam int          DEF_DATA_W      = 64;
  localparam int          DEF_NUM_LINES   = 4;
  localparam int          DEF_RESP_DELAY  = 2;

endpackage : clsu_pkg

// >>> clsu_if.sv
// interface joining the cached master and the coherent interconnect
// assumes one clock and a synchronous active-high reset for both ends
`timescale 1ns/1ps
`default_nettype none

interface clsu_if #(
  parameter int DATA_W    = clsu_pkg::DEF_DATA_W,
  parameter int NUM_LINES = clsu_pkg::DEF_NUM_LINES
) (
  input wire logic clk,
  input wire logic rst
);
  localparam int LW = (NUM_LINES > 1) ? $clog2(NUM_LINES) : 1;

  // read address channel
  logic                       ar_valid;
  logic                       ar_ready;
  clsu_pkg::clsu_op_e         ar_op;
  logic [LW-1:0]              ar_line;
  // read response channel
  logic                       r_valid;
  logic [clsu_pkg::RESP_W-1:0] r_resp;
  logic                       r_has_data;
  logic [DATA_W-1:0]          r_data;

  modport mst (
    input  clk, rst, ar_ready, r_valid, r_resp, r_has_data, r_data,
    output ar_valid, ar_op, ar_line
  );

  modport icn (
    input  clk, rst, ar_valid, ar_op, ar_line,
    output ar_ready, r_valid, r_resp, r_has_data, r_data
  );

endinterface : clsu_if

`default_nettype wire

// >>> clsu_icn.sv
// interconnect end: answers coherent reads with legal shared/dirty bits
// assumes the master accepts every response in the cycle it is shown
`timescale 1ns/1ps
`default_nettype none

module clsu_icn #(
  parameter int DATA_W     = clsu_pkg::DEF_DATA_W,
  parameter int NUM_LINES  = clsu_pkg::DEF_NUM_LINES,
  parameter int RESP_DELAY = clsu_pkg::DEF_RESP_DELAY
) (
  // link
  clsu_if.icn                 lnk,
  // other caches and memory
  input  wire logic           ext_shared,
  input  wire logic           ext_dirty,
  input  wire logic [DATA_W-1:0] mem_data,
  input  wire logic           clean_ack,
  // clean-and-invalidate request to other caches
  output logic                clean_req,
  output logic [((NUM_LINES > 1) ? $clog2(NUM_LINES) : 1)-1:0] clean_line
);
  localparam int LW = (NUM_LINES > 1) ? $clog2(NUM_LINES) : 1;
  localparam int CW = $clog2(RESP_DELAY + 1) + 1;

  typedef enum logic [1:0] {
    CLSU_R_IDLE,
    CLSU_R_CLEAN,
    CLSU_R_WAIT,
    CLSU_R_RESP
  } clsu_rst_e;

  typedef struct packed {
    clsu_rst_e              st;
    logic                   ar_ready;
    logic [CW-1:0]          cnt;
    logic                   r_valid;
    logic [1:0]             r_resp;
    logic                   r_has_data;
    logic [DATA_W-1:0]      r_data;
    logic                   clean_req;
    logic [LW-1:0]          clean_line;
  } clsu_icn_s;

  clsu_icn_s q;
  clsu_icn_s d;
  logic      shr;
  logic      drt;

  // ----------------------------------------------------------------------
  // response choice and sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    d           = q;
    d.clean_req = 1'b0;
    shr         = 1'b0;
    drt         = 1'b0;
    case (q.st)
      CLSU_R_IDLE: begin
        d.r_valid = 1'b0;
        if (lnk.ar_valid && q.ar_ready) begin
          d.ar_ready   = 1'b0;
          d.clean_line = lnk.ar_line;
          d.cnt        = CW'(RESP_DELAY);
          case (lnk.ar_op)
            // [RQ1] shared means clean
            clsu_pkg::CLSU_RD_NSD: begin
              shr = ext_shared;
              drt = ext_dirty & ~ext_shared;
            end
            clsu_pkg::CLSU_RD_SHR: begin
              shr = ext_shared;
              drt = ext_dirty;
            end
            // [RQ7] unique, dirty as held
            clsu_pkg::CLSU_RD_UNQ: begin
              shr = 1'b0;
              drt = ext_dirty;
            end
            // [RQ11] unique and clean
            default: begin
              shr = 1'b0;
              drt = 1'b0;
            end
          endcase
          d.r_resp[clsu_pkg::RESP_SHARED_BIT] = shr;
          d.r_resp[clsu_pkg::RESP_DIRTY_BIT]  = drt;
          // [RQ12] clean-unique carries no data
          d.r_has_data = (lnk.ar_op != clsu_pkg::CLSU_CL_UNQ);
          d.r_data     = (lnk.ar_op != clsu_pkg::CLSU_CL_UNQ) ? mem_data : '0;
          // [RQ10] remove other copies first
          if (lnk.ar_op == clsu_pkg::CLSU_RD_UNQ || lnk.ar_op == clsu_pkg::CLSU_CL_UNQ) begin
            d.clean_req = 1'b1;
            d.st        = CLSU_R_CLEAN;
          end else begin
            d.st = CLSU_R_WAIT;
          end
        end
      end
      // [RQ12] write back and invalidate others
      CLSU_R_CLEAN: begin
        if (clean_ack) begin
          d.st = CLSU_R_WAIT;
        end
      end
      CLSU_R_WAIT: begin
        if (q.cnt == '0) begin
          d.r_valid = 1'b1;
          d.st      = CLSU_R_RESP;
        end else begin
          d.cnt = q.cnt - CW'(1);
        end
      end
      CLSU_R_RESP: begin
        d.r_valid  = 1'b0;
        d.ar_ready = 1'b1;
        d.st       = CLSU_R_IDLE;
      end
      default: begin
        d = '0;
      end
    endcase
  end

  always_ff @(posedge lnk.clk) begin
    if (lnk.rst) begin
      q          <= '0;
      q.st       <= CLSU_R_IDLE;
      q.ar_ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign lnk.ar_ready   = q.ar_ready;
  assign lnk.r_valid    = q.r_valid;
  assign lnk.r_resp     = q.r_resp;
  assign lnk.r_has_data = q.r_has_data;
  assign lnk.r_data     = q.r_data;
  assign clean_req      = q.clean_req;
  assign clean_line     = q.clean_line;

endmodule : clsu_icn

`default_nettype wire

// >>> clsu_mst.sv
// cached master end: tracks line states across coherent read requests
// assumes loads, stores and snoops arrive on the same clock as the link
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RQ1] shared response to not-shared-dirty read is clean
// [RQ2] not-shared-dirty read from I: UC, UD, SC
// [RQ3] not-shared-dirty read from valid states per table
// [RQ4] shared read from I: UC, UD, SC, SD
// [RQ5] shared read from valid states per table
// [RQ6] SC with dirty response becomes dirty
// [RQ7] unique read: shared clear, dirty bit reports
// [RQ8] unique read from I: UC or UD
// [RQ9] unique read from valid states per table
// [RQ10] unique read returns data, line held unique
// [RQ11] clean-unique response is shared clear, dirty clear
// [RQ12] clean-unique: no data, others cleaned first
// [RQ13] clean-unique: SC to UC, SD to UD
// [RQ14] clean-unique from I, UC, UD keeps state
// [RQ15] store updates line state separately afterwards; code writes UD in the same update as the response
// [RQ16] loads normally use not-shared-dirty read
// [RQ17] stores to held shared lines use clean-unique
// [RQ18] with snoop filter, unique may be held shared
// [RQ19] without snoop filter, clean may become invalid
// [RQ20] snoop changes applied before the response
// [RQ21] issue only from listed starting states
// [RQ22] response upper bit shared, lower bit dirty
module clsu_mst #(
  parameter int DATA_W    = clsu_pkg::DEF_DATA_W,
  parameter int NUM_LINES = clsu_pkg::DEF_NUM_LINES
) (
  // link
  clsu_if.mst                      lnk,
  // load and store commands
  input  wire logic                cmd_valid,
  input  wire logic                cmd_store,
  input  wire logic [((NUM_LINES > 1) ? $clog2(NUM_LINES) : 1)-1:0] cmd_line,
  output logic                     cmd_ready,
  // snoop actions on a line
  input  wire logic                snp_valid,
  input  wire logic                snp_inval,
  input  wire logic [((NUM_LINES > 1) ? $clog2(NUM_LINES) : 1)-1:0] snp_line,
  // policy
  input  wire logic                cfg_snoop_filter,
  input  wire logic                cfg_keep_shared,
  input  wire logic                cfg_drop_clean,
  input  wire logic                cfg_allow_sd,
  // completion
  output logic                     done,
  output logic                     resp_err,
  output clsu_pkg::clsu_line_e     done_state,
  output logic [DATA_W-1:0]        done_data
);
  localparam int LW = (NUM_LINES > 1) ? $clog2(NUM_LINES) : 1;

  typedef enum logic [1:0] {
    CLSU_M_IDLE,
    CLSU_M_ADDR,
    CLSU_M_RESP
  } clsu_mst_e;

  typedef struct packed {
    clsu_mst_e                                   st;
    clsu_pkg::clsu_line_e [NUM_LINES-1:0]        lines;
    logic                                        ar_valid;
    clsu_pkg::clsu_op_e                          ar_op;
    logic [LW-1:0]                               ar_line;
    logic                                        is_store;
    logic                                        cmd_ready;
    logic                                        done;
    logic                                        resp_err;
    clsu_pkg::clsu_line_e                        done_state;
    logic [DATA_W-1:0]                           done_data;
  } clsu_mst_s;

  clsu_mst_s            q;
  clsu_mst_s            d;
  clsu_pkg::clsu_line_e cur;
  clsu_pkg::clsu_line_e nxt;

  // ----------------------------------------------------------------------
  // response legality per request and starting state
  // ----------------------------------------------------------------------
  function automatic logic resp_legal(input clsu_pkg::clsu_op_e op,
                                      input clsu_pkg::clsu_line_e st,
                                      input logic [1:0] rsp);
    logic shr;
    logic drt;
    logic ok;
    // [RQ22] decode response bits
    shr = rsp[clsu_pkg::RESP_SHARED_BIT];
    drt = rsp[clsu_pkg::RESP_DIRTY_BIT];
    ok  = 1'b1;
    case (op)
      // [RQ1] shared plus dirty refused
      clsu_pkg::CLSU_RD_NSD: ok = ~(shr & drt);
      clsu_pkg::CLSU_RD_SHR: ok = 1'b1;
      // [RQ7] shared refused
      clsu_pkg::CLSU_RD_UNQ: ok = ~shr;
      // [RQ11] only clean unique
      default:               ok = (rsp == clsu_pkg::RESP_UNQ_CLEAN);
    endcase
    if (st == clsu_pkg::CLSU_UC || st == clsu_pkg::CLSU_UD) begin
      ok = ok & (rsp == clsu_pkg::RESP_UNQ_CLEAN);
    end
    if (st == clsu_pkg::CLSU_SD) begin
      ok = ok & ~drt;
    end
    return ok;
  endfunction : resp_legal

  // ----------------------------------------------------------------------
  // expected end state
  // ----------------------------------------------------------------------
  function automatic clsu_pkg::clsu_line_e end_state(input clsu_pkg::clsu_op_e op,
                                                     input clsu_pkg::clsu_line_e st,
                                                     input logic [1:0] rsp);
    logic shr;
    logic drt;
    clsu_pkg::clsu_line_e es;
    shr = rsp[clsu_pkg::RESP_SHARED_BIT];
    // [RQ6] passed dirt or held dirt stays dirty
    drt = rsp[clsu_pkg::RESP_DIRTY_BIT] | (st == clsu_pkg::CLSU_UD) | (st == clsu_pkg::CLSU_SD);
    // [RQ2] [RQ3] [RQ4] [RQ5] [RQ8] [RQ9] [RQ13] shared/dirty select
    if (shr) begin
      es = drt ? clsu_pkg::CLSU_SD : clsu_pkg::CLSU_SC;
    end else begin
      es = drt ? clsu_pkg::CLSU_UD : clsu_pkg::CLSU_UC;
    end
    // [RQ14] clean-unique from invalid stays invalid
    if (op == clsu_pkg::CLSU_CL_UNQ && st == clsu_pkg::CLSU_I) begin
      es = clsu_pkg::CLSU_I;
    end
    return es;
  endfunction : end_state

  // ----------------------------------------------------------------------
  // permitted alternative holding for load results
  // ----------------------------------------------------------------------
  function automatic clsu_pkg::clsu_line_e relax(input clsu_pkg::clsu_line_e es,
                                                 input logic sf,
                                                 input logic keep_shr,
                                                 input logic drop);
    clsu_pkg::clsu_line_e r;
    r = es;
    // [RQ18] unique held as shared
    if (keep_shr) begin
      if (r == clsu_pkg::CLSU_UC) r = clsu_pkg::CLSU_SC;
      if (r == clsu_pkg::CLSU_UD) r = clsu_pkg::CLSU_SD;
    end
    // [RQ19] clean dropped without filter
    if (drop && !sf && (r == clsu_pkg::CLSU_UC || r == clsu_pkg::CLSU_SC)) begin
      r = clsu_pkg::CLSU_I;
    end
    return r;
  endfunction : relax

  // ----------------------------------------------------------------------
  // command, issue and response handling
  // ----------------------------------------------------------------------
  always_comb begin
    d          = q;
    d.done     = 1'b0;
    d.resp_err = 1'b0;
    nxt        = clsu_pkg::CLSU_I;
    // [RQ20] snoop applied first
    if (snp_valid) begin
      if (snp_inval) begin
        d.lines[snp_line] = clsu_pkg::CLSU_I;
      end else if (q.lines[snp_line] == clsu_pkg::CLSU_UC) begin
        d.lines[snp_line] = clsu_pkg::CLSU_SC;
      end else if (q.lines[snp_line] == clsu_pkg::CLSU_UD) begin
        d.lines[snp_line] = clsu_pkg::CLSU_SD;
      end
    end
    cur = d.lines[(q.st == CLSU_M_IDLE) ? cmd_line : q.ar_line];
    case (q.st)
      CLSU_M_IDLE: begin
        if (cmd_valid && q.cmd_ready) begin
          d.is_store = cmd_store;
          d.ar_line  = cmd_line;
          if (cmd_store && (cur == clsu_pkg::CLSU_UC || cur == clsu_pkg::CLSU_UD)) begin
            // [RQ15] local store on unique line
            d.lines[cmd_line] = clsu_pkg::CLSU_UD;
            d.done            = 1'b1;
            d.done_state      = clsu_pkg::CLSU_UD;
          end else if (!cmd_store && cur != clsu_pkg::CLSU_I) begin
            d.done       = 1'b1;
            d.done_state = cur;
          end else begin
            // [RQ21] only listed start states issue
            if (cmd_store) begin
              // [RQ17] held copy uses clean-unique
              d.ar_op = (cur == clsu_pkg::CLSU_I) ? clsu_pkg::CLSU_RD_UNQ
                                                  : clsu_pkg::CLSU_CL_UNQ;
            end else begin
              // [RQ16] loads prefer not-shared-dirty
              d.ar_op = cfg_allow_sd ? clsu_pkg::CLSU_RD_SHR : clsu_pkg::CLSU_RD_NSD;
            end
            d.ar_valid  = 1'b1;
            d.cmd_ready = 1'b0;
            d.st        = CLSU_M_ADDR;
          end
        end
      end
      CLSU_M_ADDR: begin
        if (lnk.ar_ready) begin
          d.ar_valid = 1'b0;
          d.st       = CLSU_M_RESP;
        end
      end
      CLSU_M_RESP: begin
        if (lnk.r_valid) begin
          if (lnk.r_has_data) begin
            d.done_data = lnk.r_data;
          end
          if (!resp_legal(q.ar_op, cur, lnk.r_resp)) begin
            d.resp_err   = 1'b1;
            d.done       = 1'b1;
            d.done_state = cur;
            d.cmd_ready  = 1'b1;
            d.st         = CLSU_M_IDLE;
          end else begin
            nxt = end_state(q.ar_op, cur, lnk.r_resp);
            if (!q.is_store) begin
              nxt = relax(nxt, cfg_snoop_filter, cfg_keep_shared & cfg_snoop_filter,
                          cfg_drop_clean);
            end
            if (q.is_store && nxt == clsu_pkg::CLSU_I) begin
              // line lost under clean-unique: fetch it with a unique read
              d.lines[q.ar_line] = nxt;
              d.ar_op            = clsu_pkg::CLSU_RD_UNQ;
              d.ar_valid         = 1'b1;
              d.st               = CLSU_M_ADDR;
            end else begin
              // [RQ10] [RQ15] store lands atomically once unique
              if (q.is_store) begin
                nxt = clsu_pkg::CLSU_UD;
              end
              d.lines[q.ar_line] = nxt;
              d.done             = 1'b1;
              d.done_state       = nxt;
              d.cmd_ready        = 1'b1;
              d.st               = CLSU_M_IDLE;
            end
          end
        end
      end
      default: begin
        d.st        = CLSU_M_IDLE;
        d.cmd_ready = 1'b1;
        d.ar_valid  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge lnk.clk) begin
    if (lnk.rst) begin
      q           <= '0;
      q.st        <= CLSU_M_IDLE;
      q.cmd_ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign lnk.ar_valid = q.ar_valid;
  assign lnk.ar_op    = q.ar_op;
  assign lnk.ar_line  = q.ar_line;
  assign cmd_ready    = q.cmd_ready;
  assign done         = q.done;
  assign resp_err     = q.resp_err;
  assign done_state   = q.done_state;
  assign done_data    = q.done_data;

endmodule : clsu_mst

`default_nettype wire

// >>> clsu_chk.sv
// checker for the coherent read link: response bits and handshake timing
// assumes it sees the link signals between the master and interconnect ends
`timescale 1ns/1ps
`default_nettype none

module clsu_chk #(
  parameter int DATA_W    = 64,
  parameter int NUM_LINES = 4
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // read address channel
  input wire logic                ar_valid,
  input wire logic                ar_ready,
  input wire clsu_pkg::clsu_op_e  ar_op,
  input wire logic [((NUM_LINES > 1) ? $clog2(NUM_LINES) : 1)-1:0] ar_line,
  // read response channel
  input wire logic                r_valid,
  input wire logic [1:0]          r_resp,
  input wire logic                r_has_data,
  input wire logic [DATA_W-1:0]   r_data
);
  clsu_pkg::clsu_op_e op_q;
  logic               hs;

  assign hs = ar_valid && ar_ready;

  // remembers the kind of the outstanding request
  always_ff @(posedge clk) begin
    if (rst) begin
      op_q <= clsu_pkg::CLSU_RD_NSD;
    end else if (hs) begin
      op_q <= ar_op;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // --------------------------------------------------------------------
  // response bits
  // --------------------------------------------------------------------
  chk_nsd_shared_clean: assert property (
    r_valid && op_q == clsu_pkg::CLSU_RD_NSD |-> r_resp != 2'h3)
    else $error("shared and dirty answer to a not-shared-dirty read");
  chk_unq_not_shared: assert property (
    r_valid && op_q == clsu_pkg::CLSU_RD_UNQ |-> !r_resp[1])
    else $error("shared answer to a unique read");
  chk_cu_resp_zero: assert property (
    r_valid && op_q == clsu_pkg::CLSU_CL_UNQ |-> r_resp == 2'h0)
    else $error("clean-unique answer not zero");
  chk_cu_no_data: assert property (
    r_valid && op_q == clsu_pkg::CLSU_CL_UNQ |-> !r_has_data)
    else $error("clean-unique answer carries data");
  chk_unq_has_data: assert property (
    r_valid && op_q == clsu_pkg::CLSU_RD_UNQ |-> r_has_data)
    else $error("unique read answer without data");

  // --------------------------------------------------------------------
  // handshake timing
  // --------------------------------------------------------------------
  chk_req_held: assert property (
    ar_valid && !ar_ready |=> ar_valid && $stable(ar_op) && $stable(ar_line))
    else $error("request changed before it was taken");
  chk_busy_after_take: assert property (
    hs |=> !ar_ready && !r_valid)
    else $error("link not busy after a request was taken");
  chk_resp_bound: assert property (
    hs |-> ##[2:60] r_valid)
    else $error("no answer within the bound");
  chk_ready_after_resp: assert property (
    r_valid |=> ar_ready && !r_valid)
    else $error("answer not a single pulse followed by ready");

  cover property (r_valid && op_q == clsu_pkg::CLSU_CL_UNQ);
  cover property (r_valid && op_q == clsu_pkg::CLSU_RD_SHR && r_resp == 2'h3);
  cover property (r_valid && op_q == clsu_pkg::CLSU_RD_UNQ && r_resp[0]);

endmodule : clsu_chk

`default_nettype wire

// >>> tb_top.sv
// self-checking bench: master and interconnect joined by their link
// assumes both ends share clk and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 cmd_valid = 1'b0;
  logic                 cmd_store = 1'b0;
  logic [1:0]           cmd_line = 2'h0;
  logic                 snp_valid = 1'b0;
  logic                 snp_inval = 1'b0;
  logic [1:0]           snp_line = 2'h0;
  logic                 cfg_snoop_filter = 1'b0;
  logic                 cfg_keep_shared = 1'b0;
  logic                 cfg_drop_clean = 1'b0;
  logic                 cfg_allow_sd = 1'b0;
  logic                 ext_shared = 1'b0;
  logic                 ext_dirty = 1'b0;
  logic [63:0]          mem_data = 64'h0;
  logic [1:0]           ack_sr = 2'h0;
  wire logic            clean_ack;
  logic                 cmd_ready;
  logic                 done;
  logic                 resp_err;
  logic                 clean_req;
  logic [1:0]           clean_line;
  logic [63:0]          done_data;
  clsu_pkg::clsu_line_e done_state;
  int                   failures = 0;
  int                   comparisons = 0;
  int                   cycles = 0;
  clsu_pkg::clsu_line_e nsd_exp [4] = '{clsu_pkg::CLSU_UC, clsu_pkg::CLSU_UD,
                                        clsu_pkg::CLSU_SC, clsu_pkg::CLSU_SC};
  clsu_pkg::clsu_line_e shr_exp [4] = '{clsu_pkg::CLSU_UC, clsu_pkg::CLSU_UD,
                                        clsu_pkg::CLSU_SC, clsu_pkg::CLSU_SD};

  always #5 clk = ~clk;

  // other caches acknowledge a clean two cycles after the request
  always @(negedge clk) begin
    ack_sr <= {ack_sr[0], clean_req};
  end
  assign clean_ack = ack_sr[1];

  // other caches must be told which line to clean
  always @(negedge clk) begin
    if (clean_req === 1'b1) begin
      check("clean line", 64'(cmd_line), 64'(clean_line));
    end
  end

  clsu_if clsu_if_i (.clk(clk), .rst(rst));

  clsu_mst clsu_mst_i (
    .lnk(clsu_if_i.mst), .cmd_valid(cmd_valid), .cmd_store(cmd_store),
    .cmd_line(cmd_line), .cmd_ready(cmd_ready), .snp_valid(snp_valid),
    .snp_inval(snp_inval), .snp_line(snp_line), .cfg_snoop_filter(cfg_snoop_filter),
    .cfg_keep_shared(cfg_keep_shared), .cfg_drop_clean(cfg_drop_clean),
    .cfg_allow_sd(cfg_allow_sd), .done(done), .resp_err(resp_err),
    .done_state(done_state), .done_data(done_data));

  clsu_icn clsu_icn_i (
    .lnk(clsu_if_i.icn), .ext_shared(ext_shared), .ext_dirty(ext_dirty),
    .mem_data(mem_data), .clean_ack(clean_ack), .clean_req(clean_req),
    .clean_line(clean_line));

  clsu_chk clsu_chk_i (
    .clk(clk), .rst(rst), .ar_valid(clsu_if_i.ar_valid), .ar_ready(clsu_if_i.ar_ready),
    .ar_op(clsu_if_i.ar_op), .ar_line(clsu_if_i.ar_line), .r_valid(clsu_if_i.r_valid),
    .r_resp(clsu_if_i.r_resp), .r_has_data(clsu_if_i.r_has_data),
    .r_data(clsu_if_i.r_data));

  task automatic end_sim();
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_sim();
    end
  end

  task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : check

  task automatic snoop(input logic [1:0] ln, input logic inv);
    @(negedge clk);
    snp_valid = 1'b1;
    snp_inval = inv;
    snp_line = ln;
    @(negedge clk);
    snp_valid = 1'b0;
  endtask : snoop

  task automatic inv_all();
    for (int i = 0; i < 4; i++) begin
      snoop(2'(i), 1'b1);
    end
  endtask : inv_all

  // one command; optional invalidating snoop while it is outstanding
  task automatic op(input logic st, input logic [1:0] ln, input logic snp,
                    input clsu_pkg::clsu_line_e exp, input logic dchk);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_store = st;
    cmd_line = ln;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      snp_valid = snp && n == 0;
      snp_inval = 1'b1;
      snp_line = ln;
      @(negedge clk);
      n++;
    end
    snp_valid = 1'b0;
    check("done seen", 64'h1, 64'(done));
    check("end state", 64'(exp), 64'(done_state));
    check("error flag", 64'h0, 64'(resp_err));
    check("ready at done", 64'h1, 64'(cmd_ready));
    if (dchk) begin
      check("line data", mem_data, done_data);
    end
  endtask : op

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("ready after reset", 64'h1, 64'(cmd_ready));
    check("state after reset", 64'(clsu_pkg::CLSU_I), 64'(done_state));
    for (int i = 0; i < 4; i++) begin
      ext_shared = i[1];
      ext_dirty = i[0];
      mem_data = 64'hC0DE_0000_0000_0000 + 64'(i);
      op(1'b0, 2'(i), 1'b0, nsd_exp[i], 1'b1);
    end
    op(1'b1, 2'h2, 1'b0, clsu_pkg::CLSU_UD, 1'b0);
    op(1'b1, 2'h3, 1'b1, clsu_pkg::CLSU_UD, 1'b1);
    op(1'b1, 2'h1, 1'b0, clsu_pkg::CLSU_UD, 1'b0);
    op(1'b0, 2'h0, 1'b0, clsu_pkg::CLSU_UC, 1'b0);
    inv_all();
    cfg_allow_sd = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ext_shared = i[1];
      ext_dirty = i[0];
      mem_data = 64'h5EED_0000_0000_0000 + 64'(i);
      op(1'b0, 2'(i), 1'b0, shr_exp[i], 1'b1);
    end
    snoop(2'h0, 1'b0);
    op(1'b0, 2'h0, 1'b0, clsu_pkg::CLSU_SC, 1'b0);
    op(1'b1, 2'h3, 1'b0, clsu_pkg::CLSU_UD, 1'b0);
    inv_all();
    cfg_allow_sd = 1'b0;
    ext_shared = 1'b0;
    ext_dirty = 1'b1;
    mem_data = 64'hBEEF_0000_0000_0001;
    op(1'b1, 2'h0, 1'b0, clsu_pkg::CLSU_UD, 1'b1);
    ext_dirty = 1'b0;
    mem_data = 64'hBEEF_0000_0000_0002;
    op(1'b1, 2'h1, 1'b0, clsu_pkg::CLSU_UD, 1'b1);
    inv_all();
    cfg_snoop_filter = 1'b1;
    cfg_keep_shared = 1'b1;
    op(1'b0, 2'h2, 1'b0, clsu_pkg::CLSU_SC, 1'b1);
    ext_dirty = 1'b1;
    op(1'b0, 2'h3, 1'b0, clsu_pkg::CLSU_SD, 1'b1);
    cfg_snoop_filter = 1'b0;
    cfg_keep_shared = 1'b0;
    cfg_drop_clean = 1'b1;
    ext_dirty = 1'b0;
    op(1'b0, 2'h0, 1'b0, clsu_pkg::CLSU_I, 1'b1);
    ext_shared = 1'b1;
    op(1'b0, 2'h1, 1'b0, clsu_pkg::CLSU_I, 1'b1);
    end_sim();
  end

endmodule : tb_top

`default_nettype wire
